// >>> pkg/cep_defs.svh
/*
 Register offsets, reset values, priority levels and field positions
 of the core event prioritizer. Assumes APB byte addresses in paddr[7:0].
*/
`ifndef CEP_DEFS_SVH
`define CEP_DEFS_SVH
`define CEP_NUM_LVL 16
`define CEP_NUM_GP 9
`define CEP_LVL_EMU 4'h0
`define CEP_LVL_RST 4'h1
`define CEP_LVL_NMI 4'h2
`define CEP_LVL_EXC 4'h3
`define CEP_LVL_HWE 4'h5
`define CEP_LVL_TMR 4'h6
`define CEP_LVL_GP0 4'h7
`define CEP_OFS_LATCH 8'h00
`define CEP_OFS_MASK 8'h04
`define CEP_OFS_ACTIVE 8'h08
`define CEP_OFS_CTRL 8'h0c
`define CEP_OFS_STATUS 8'h10
`define CEP_OFS_IRQMASK 8'h14
`define CEP_OFS_SWRAISE 8'h18
`define CEP_FIXED_MASK 16'h000f
`define CEP_GP_MASK 16'hff80
`define CEP_MASK_RST 16'h000f
`define CEP_CTRL_RST 1'b1
`define CEP_ST_W 3
`define CEP_ST_TAKEN 0
`define CEP_ST_RET 1
`define CEP_ST_LOST 2
`endif

// >>> pkg/cep_pkg.sv
/*
 Types of the core event prioritizer: levels, event vectors, APB request
 bundle and the event offered to the core. Assumes 16 priority levels.
*/
package cep_pkg;
	typedef logic [3:0] cep_level_t;
	typedef logic [15:0] cep_vec_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} cep_apb_req_t;
	typedef struct packed {
		logic valid;
		cep_level_t level;
	} cep_evt_t;
	typedef enum {APB_IDLE, APB_ACCESS} cep_apb_state_t;
endpackage

// >>> rtl/cep_top.sv
/*
 Core event prioritizer: latches dedicated and general events, masks,
 ranks and offers the best one to the core, tracks nesting.
 Assumes core-side requests are synchronous to clk_sys; pins are not.
*/
// Notes on behaviour
// RQ1 - Dedicated events rank emulation 0, reset 1, NMI 2, exception 3, ...
// RQ2 - General interrupts sit at levels 7 up, below every dedicated event.
// RQ3 - Nine general interrupt inputs feed levels 7 through 15.
// RQ4 - Software should keep levels 14 and 15 for software handlers.
// RQ5 - Nested handlers; a higher priority event preempts lower ones.
// RQ6 - Taking emulation puts the processor in emulation mode.
// RQ7 - Taking reset resets the processor; second highest priority.
// RQ8 - NMI comes from the watchdog or the external NMI pin.
// RQ9 - Exceptions are taken synchronously, before the instruction completes.
// RQ10 - Interrupts arrive asynchronously, including a software raise.
// RQ11 - Each level captures its own return address when taken.
// RQ12 - Taking an event saves processor state on the supervisor stack.
// RQ13 - Peripheral router drives the general inputs directly.
// RQ14 - A rising edge sets the latch bit; detection takes two cycles.
// RQ15 - The latch bit clears when its active bit sets.
// RQ16 - Set mask bit allows service; cleared bit blocks a latched event.
// RQ17 - Pending comes no sooner than three cycles after an input edge; core-side inputs such as emuReq latch one cycle after theirs.
// RQ18 - Offer best unmasked latched event only above every active level.
`timescale 1ns/10ps
`include "cep_defs.svh"
module cep_top #(
	parameter int NumGp = `CEP_NUM_GP
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire cep_pkg::cep_apb_req_t apbReq,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic emuReq,
	input wire logic resetReq,
	input wire logic nmiPin,
	input wire logic wdogNmi,
	input wire logic excReq,
	input wire logic hwErrReq,
	input wire logic timerReq,
	input wire logic [NumGp-1:0] gpIrqPin,
	input wire logic [31:0] resumePc,
	input wire logic coreAccept,
	input wire logic coreReturn,
	input wire cep_pkg::cep_level_t retLevel,
	output cep_pkg::cep_evt_t evtOut,
	output logic [31:0] retAddr,
	output logic emuMode,
	output logic coreResetReq,
	output logic saveState,
	output logic irq
);
	import cep_pkg::*;

	if (NumGp + 7 != `CEP_NUM_LVL) begin : g_badGp
		$error("NumGp must fill levels 7 to 15");
	end

	cep_vec_t latch_r, latch_nxt, mask_r, mask_nxt, active_r, active_nxt;
	cep_vec_t effMask, rawIn, inPrev_r, edgeIn, swSet, swClr, accClr;
	logic [NumGp-1:0] gpMeta_r, gpSync_r;
	logic nmiMeta_r, nmiSync_r, gpEnable_r, gpEnable_nxt;
	logic [`CEP_ST_W-1:0] status_r, statusMask_r, stSet, stClr;
	logic [31:0] retStore_r [`CEP_NUM_LVL];
	logic [31:0] rdMux;
	cep_apb_state_t apbState_r;
	cep_evt_t selNxt;
	logic apbWr, apbRd, accept, rdHit;

	// Pins come from outside the clock domain and pass two flip-flops.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			gpMeta_r <= '0;
			gpSync_r <= '0;
			nmiMeta_r <= 1'b0;
			nmiSync_r <= 1'b0;
		end else begin
			gpMeta_r <= gpIrqPin;
			gpSync_r <= gpMeta_r; // RQ14
			nmiMeta_r <= nmiPin;
			nmiSync_r <= nmiMeta_r;
		end
	end

	always_comb begin
		rawIn = '0;
		rawIn[`CEP_LVL_EMU] = emuReq;
		rawIn[`CEP_LVL_RST] = resetReq;
		rawIn[`CEP_LVL_NMI] = nmiSync_r | wdogNmi; // RQ8
		rawIn[`CEP_LVL_EXC] = excReq; // RQ9
		rawIn[`CEP_LVL_HWE] = hwErrReq;
		rawIn[`CEP_LVL_TMR] = timerReq;
		rawIn[`CEP_NUM_LVL-1:`CEP_LVL_GP0] = gpSync_r; // RQ3 RQ13 RQ10
	end

	assign edgeIn = rawIn & ~inPrev_r; // RQ14
	assign apbWr = apbReq.psel & apbReq.penable & apbReq.pwrite & pready;
	assign apbRd = apbReq.psel & apbReq.penable & ~apbReq.pwrite & pready;
	assign accept = coreAccept & evtOut.valid;

	always_comb begin
		swSet = '0;
		swClr = '0;
		accClr = '0;
		if (apbWr && apbReq.paddr == `CEP_OFS_SWRAISE)
			swSet = apbReq.pwdata[15:0] & `CEP_GP_MASK; // RQ10
		// Software may cancel a latched event only while it is masked.
		if (apbWr && apbReq.paddr == `CEP_OFS_LATCH)
			swClr = apbReq.pwdata[15:0] & ~mask_r;
		if (accept)
			accClr[evtOut.level] = 1'b1; // RQ15
		latch_nxt = (latch_r & ~swClr & ~accClr) | edgeIn | swSet; // RQ14
		active_nxt = active_r;
		if (coreReturn)
			active_nxt[retLevel] = 1'b0;
		active_nxt = active_nxt | accClr; // RQ5
		mask_nxt = mask_r;
		if (apbWr && apbReq.paddr == `CEP_OFS_MASK)
			mask_nxt = apbReq.pwdata[15:0] | `CEP_FIXED_MASK;
		gpEnable_nxt = gpEnable_r;
		if (apbWr && apbReq.paddr == `CEP_OFS_CTRL)
			gpEnable_nxt = apbReq.pwdata[0];
		effMask = mask_nxt & (gpEnable_nxt ? 16'hffff : ~`CEP_GP_MASK); // RQ16
	end

	// Lowest index wins; it must also beat every active level.
	always_comb begin
		cep_vec_t cand;
		cand = latch_nxt & effMask;
		selNxt = '0;
		for (int i = `CEP_NUM_LVL - 1; i >= 0; i--) begin
			if (cand[i]) begin
				selNxt.valid = 1'b1; // RQ1 RQ2
				selNxt.level = cep_level_t'(i);
			end
		end
		for (int i = 0; i < `CEP_NUM_LVL; i++) begin
			if (active_nxt[i] && cep_level_t'(i) <= selNxt.level)
				selNxt.valid = 1'b0; // RQ18 RQ5
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			latch_r <= '0;
			active_r <= '0;
			inPrev_r <= '0;
			evtOut <= '0;
		end else begin
			latch_r <= latch_nxt;
			active_r <= active_nxt;
			inPrev_r <= rawIn;
			evtOut <= selNxt; // RQ17
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mask_r <= `CEP_MASK_RST;
			gpEnable_r <= `CEP_CTRL_RST;
			statusMask_r <= '0;
		end else begin
			mask_r <= mask_nxt;
			gpEnable_r <= gpEnable_nxt;
			if (apbWr && apbReq.paddr == `CEP_OFS_IRQMASK)
				statusMask_r <= apbReq.pwdata[`CEP_ST_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			emuMode <= 1'b0;
			coreResetReq <= 1'b0;
			saveState <= 1'b0;
		end else begin
			saveState <= accept; // RQ12
			coreResetReq <= accept && evtOut.level == `CEP_LVL_RST; // RQ7
			if (accept && evtOut.level == `CEP_LVL_EMU)
				emuMode <= 1'b1; // RQ6
			else if (coreReturn && retLevel == `CEP_LVL_EMU)
				emuMode <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < `CEP_NUM_LVL; i++)
				retStore_r[i] <= '0;
			retAddr <= '0;
		end else begin
			if (accept)
				retStore_r[evtOut.level] <= resumePc; // RQ11
			retAddr <= retStore_r[retLevel];
		end
	end

	// Sticky status, cleared by reading; a new event wins over the clear.
	always_comb begin
		stSet = '0;
		stSet[`CEP_ST_TAKEN] = accept;
		stSet[`CEP_ST_RET] = coreReturn;
		stSet[`CEP_ST_LOST] = |(edgeIn & latch_r & ~accClr);
		stClr = '0;
		if (apbRd && apbReq.paddr == `CEP_OFS_STATUS)
			stClr = prdata[`CEP_ST_W-1:0];
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			status_r <= '0;
			irq <= 1'b0;
		end else begin
			status_r <= (status_r & ~stClr) | stSet;
			irq <= |(status_r & statusMask_r);
		end
	end

	always_comb begin
		rdHit = 1'b1;
		rdMux = '0;
		case (apbReq.paddr)
			`CEP_OFS_LATCH: rdMux[15:0] = latch_r;
			`CEP_OFS_MASK: rdMux[15:0] = mask_r;
			`CEP_OFS_ACTIVE: rdMux[15:0] = active_r;
			`CEP_OFS_CTRL: rdMux[0] = gpEnable_r;
			`CEP_OFS_STATUS: rdMux[`CEP_ST_W-1:0] = status_r;
			`CEP_OFS_IRQMASK: rdMux[`CEP_ST_W-1:0] = statusMask_r;
			`CEP_OFS_SWRAISE: rdMux = '0;
			default: rdHit = 1'b0;
		endcase
	end

	// One wait-free access phase: pready rises the cycle after setup.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			apbState_r <= APB_IDLE;
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			case (apbState_r)
				APB_IDLE: begin
					if (apbReq.psel && !apbReq.penable) begin
						apbState_r <= APB_ACCESS;
						pready <= 1'b1;
						prdata <= apbReq.pwrite ? 32'h0 : rdMux;
						pslverr <= !rdHit;
					end
				end
				APB_ACCESS: begin
					apbState_r <= APB_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
				default: apbState_r <= APB_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	a_prio_order: assert property (evtOut.valid |-> // RQ1
		(latch_r & mask_r & ((16'h1 << evtOut.level) - 16'h1)) == 16'h0 &&
		latch_r[evtOut.level])
		else $error("offered event is not the best latched one");
	a_gp_below: assert property ( // RQ2
		evtOut.valid && evtOut.level >= 4'h7 |->
		(latch_r & mask_r & 16'h007f) == 16'h0)
		else $error("general level beat a dedicated event");
	a_nest_block: assert property (evtOut.valid |-> // RQ18
		(active_r & ((16'h2 << evtOut.level) - 16'h1)) == 16'h0)
		else $error("event offered below an active level");
	a_mask_gate: assert property (evtOut.valid |-> mask_r[evtOut.level]) // RQ16
		else $error("masked event offered");
	a_accept_act: assert property (accept |=> // RQ15
		active_r[$past(evtOut.level)] && saveState)
		else $error("accepted event not active");
	a_emu_enter: assert property (accept && evtOut.level == 4'h0 |=> // RQ6
		emuMode)
		else $error("emulation mode not entered");
	a_reset_pulse: assert property (accept && evtOut.level == 4'h1 |=> // RQ7
		coreResetReq ##1 !coreResetReq || accept)
		else $error("reset request not a pulse");
	a_ret_store: assert property (accept |=> // RQ11
		retStore_r[$past(evtOut.level)] == $past(resumePc))
		else $error("return address not captured");
	a_edge_latch: assert property ($rose(gpSync_r[0]) |=> // RQ14
		latch_r[7] || active_r[7])
		else $error("general edge not latched");
	a_nmi_wdog: assert property ($rose(wdogNmi) |=> latch_r[2] || active_r[2]) // RQ8
		else $error("watchdog NMI not latched");
	// The synchroniser must delay the offer by at least one more cycle.
	a_gp_latency: assert property ( // RQ17
		$rose(gpMeta_r[0]) && !latch_r[7] |->
		##1 !(evtOut.valid && evtOut.level == 4'h7))
		else $error("general event offered too early");

	c_nested: cover property (accept ##[1:20] accept && active_r != 16'h0);
	c_return: cover property (coreReturn && active_r[retLevel]);
	c_irq: cover property (irq ##1 apbRd);
endmodule // cep_top

// >>> test/cep_core_model.sv
/*
 Behavioural core pipeline: takes offered events and returns from them.
 Assumes the prioritizer's core-side contract on clk_sys.
*/
`timescale 1ns/10ps
module cep_core_model (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire cep_pkg::cep_evt_t evtOut,
	output logic coreAccept,
	output logic coreReturn,
	output cep_pkg::cep_level_t retLevel,
	output logic [31:0] resumePc
);
	import cep_pkg::*;
	cep_level_t stk[$];
	int waitN;
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			coreAccept <= 1'b0;
			coreReturn <= 1'b0;
			retLevel <= '0;
			resumePc <= '0;
			waitN <= 0;
			stk.delete();
		end else begin
			coreAccept <= 1'b0;
			coreReturn <= 1'b0;
			if (coreAccept && evtOut.valid === 1'b1) begin
				stk.push_back(evtOut.level);
				waitN <= 3 + $urandom_range(0, 3);
			end else if (waitN > 0) begin
				waitN <= waitN - 1;
			end else if (evtOut.valid === 1'b1) begin
				coreAccept <= 1'b1;
				resumePc <= $urandom;
			end else if (stk.size() > 0) begin
				// Nested handlers finish innermost first.
				coreReturn <= 1'b1;
				retLevel <= stk.pop_back();
				waitN <= 2;
			end
		end
	end
endmodule // cep_core_model

// >>> test/cep_top_test.sv
/*
 Self-checking bench of the core event prioritizer with an APB master.
 Assumes the core model answers offered events on the far side.
*/
`timescale 1ns/10ps
`include "cep_defs.svh"
`define CHK(a, e) begin \
	checked++; \
	if ((a) !== (e)) begin \
		errCount++; \
		$display("BAD %0t got %h exp %h", $time, a, e); \
	end \
end
module cep_top_test;
	import cep_pkg::*;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	cep_apb_req_t apbReq = '0;
	logic [31:0] prdata, retAddr, resumePc;
	logic pready, pslverr, emuReq = 0, nmiPin = 0, wdogNmi = 0, excReq = 0;
	logic hwErrReq = 0, timerReq = 0, resetReq = 0, coreAccept, coreReturn;
	logic emuMode, coreResetReq, saveState, irq;
	logic [8:0] gpIrqPin = '0;
	cep_level_t retLevel;
	cep_evt_t evtOut;
	logic [32:0] rdQ[$];
	cep_level_t evQ[$];
	int errCount = 0;
	int checked = 0;
	logic accD = 1'b0;
	logic retD = 1'b0;
	cep_level_t accLvl;
	logic [31:0] retExp;
	logic [31:0] pcSeen [16];
	always #25 clk_sys = ~clk_sys;
	cep_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .apbReq(apbReq),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.emuReq(emuReq), .resetReq(resetReq), .nmiPin(nmiPin),
		.wdogNmi(wdogNmi), .excReq(excReq), .hwErrReq(hwErrReq),
		.timerReq(timerReq), .gpIrqPin(gpIrqPin), .resumePc(resumePc),
		.coreAccept(coreAccept), .coreReturn(coreReturn),
		.retLevel(retLevel), .evtOut(evtOut), .retAddr(retAddr),
		.emuMode(emuMode), .coreResetReq(coreResetReq),
		.saveState(saveState), .irq(irq));
	cep_core_model core (.clk_sys(clk_sys), .reset_n(reset_n),
		.evtOut(evtOut), .coreAccept(coreAccept), .coreReturn(coreReturn),
		.retLevel(retLevel), .resumePc(resumePc));
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		apbReq <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk_sys);
		apbReq.penable <= 1'b1;
		// Only pready or the watchdog ends a wait for the slave's answer.
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		apbReq <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		rdQ.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic drain();
		// A missing event hangs here until the watchdog fails the run.
		while (evQ.size() > 0) begin
			@(posedge clk_sys);
		end
		repeat (20) @(posedge clk_sys);
	endtask
	task automatic wrap_up();
		$display("checked %0d errors %0d", checked, errCount);
		if (errCount == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		if (apbReq.psel && apbReq.penable && pready === 1'b1
			&& !apbReq.pwrite && rdQ.size() > 0) begin
			`CHK({pslverr, prdata}, rdQ.pop_front())
		end
		if (accD) begin
			`CHK(saveState, 1'b1)
			`CHK(coreResetReq, (accLvl == `CEP_LVL_RST))
		end
		if (retD) begin
			`CHK(retAddr, retExp)
		end
		accD = coreAccept === 1'b1 && evtOut.valid === 1'b1;
		accLvl = evtOut.level;
		retD = coreReturn === 1'b1;
		retExp = pcSeen[retLevel];
		if (accD) begin
			pcSeen[evtOut.level] = resumePc;
		end
		if (coreAccept && evtOut.valid === 1'b1 && evQ.size() > 0) begin
			`CHK(evtOut.level, evQ.pop_front())
		end
		if (coreReturn && retLevel == `CEP_LVL_EMU) begin
			`CHK(emuMode, 1'b1)
		end
	end
	initial begin
		repeat (40000) @(posedge clk_sys);
		errCount++;
		wrap_up();
	end
	initial begin
		void'($urandom(85));
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd(`CEP_OFS_MASK, 33'h00000000f);
		rd(`CEP_OFS_CTRL, 33'h000000001);
		rd(`CEP_OFS_ACTIVE, 33'h0);
		rd(8'h1c + 8'(4 * $urandom_range(0, 8)), 33'h100000000);
		apb(1'b1, `CEP_OFS_MASK, 32'h0000ffff);
		evQ = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h7};
		@(posedge clk_sys);
		{emuReq, resetReq, nmiPin, hwErrReq, timerReq, gpIrqPin[0]} <= '1;
		@(posedge clk_sys);
		{emuReq, resetReq, nmiPin, hwErrReq, timerReq, gpIrqPin[0]} <= '0;
		drain();
		// Higher events arrive while level 8 is being serviced.
		evQ = '{4'h8, 4'h2, 4'h3};
		gpIrqPin[1] <= 1'b1;
		@(posedge clk_sys iff (coreAccept && evtOut.valid === 1'b1));
		{excReq, wdogNmi} <= 2'b11;
		gpIrqPin[1] <= 1'b0;
		@(posedge clk_sys);
		{excReq, wdogNmi} <= 2'b00;
		drain();
		apb(1'b1, `CEP_OFS_IRQMASK, 32'h1);
		// The irq output follows the new mask one registered cycle later.
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b1)
		rd(`CEP_OFS_STATUS, 33'h000000003);
		rd(`CEP_OFS_STATUS, 33'h0);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b0)
		apb(1'b1, `CEP_OFS_MASK, 32'h0000feff);
		gpIrqPin[1] <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rd(`CEP_OFS_LATCH, 33'h000000100);
		rd(`CEP_OFS_ACTIVE, 33'h0);
		apb(1'b1, `CEP_OFS_LATCH, 32'h00000100);
		rd(`CEP_OFS_LATCH, 33'h0);
		evQ = '{4'hf};
		apb(1'b1, `CEP_OFS_SWRAISE, 32'h00008000);
		drain();
		wrap_up();
	end
endmodule // cep_top_test
